//--- hw/lvd_pkg.sv
// Function
// - External reset loads the control register with all zeros.
// - Bit 7 turns detection on and starts the comparator.
// - Bit 4 switches the reference generator off or on.
// - Bit 1 picks interrupt (0) or internal reset (1) on under-voltage.
// - Bit 0 reads 1 only while supply is below threshold and detecting.
// - Interrupt request follows the flag only when on and interrupt mode.
// - Control bits clear on any reset except one caused by this detector.
// - A detector reset sets bit 0 of the reset cause register.
// - With power-on clear fitted, reference always runs; its bit ignored.
// - Control register accepts single-bit and full-byte writes.
// - Detection and its response are registered on clk and stop updating while the clock is stopped.
// - Threshold is software-selectable, eight levels in the full variant.
// - Level select register holds 3-bit field, cleared on external reset.
package lvd_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [15:0] UNDERVOLTAGE_CONTROL_ADDR = 16'hFFBE;
   localparam logic [15:0] LEVEL_SELECT_ADDR = 16'hFFBF;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] LEVEL_RESET = 8'h00;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int DETECTOR_ON_BIT = 7;
   localparam int REFERENCE_ENABLE_BIT = 4;
   localparam int RESPONSE_SELECT_BIT = 1;
   localparam int FLAG_BIT = 0;
   localparam int LEVEL_WIDTH = 3;
   localparam int CAUSE_BIT = 0;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'h92;
   localparam logic [7:0] LEVEL_WRITE_MASK = 8'h07;
   // ------------------------------------------------------------
   // Software wait times, for reference
   // ------------------------------------------------------------
   localparam real COMPARE_SETTLE_MS = 0.2;
   localparam real REFERENCE_SETTLE_MS = 2.0;
endpackage

//--- hw/lvd_bitwr.sv
module lvd_bitwr #(
   parameter logic [7:0] MASK = 8'hFF
) (
   // Current value and write request
   input wire logic [7:0] cur,
   input wire logic [7:0] wdata,
   input wire logic wr_byte,
   input wire logic wr_bit,
   input wire logic [2:0] bit_sel,
   // Result
   output logic [7:0] result
);
   always_comb begin
      result = cur;
      if (wr_byte) begin
         result = (cur & ~MASK) | (wdata & MASK);
      end else if (wr_bit && MASK[bit_sel]) begin
         result[bit_sel] = wdata[bit_sel];
      end
   end
endmodule // lvd_bitwr

//--- hw/lvd_control.sv
module lvd_control #(
   parameter bit POC_FITTED = 1'b0,
   parameter int LEVELS = 8
) (
   // Clock and resets
   input wire logic clk,
   input wire logic reset_n,
   input wire logic internal_reset,
   // Register access
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_byte,
   input wire logic wr_bit,
   input wire logic [2:0] bit_sel,
   output logic [7:0] rdata,
   // Analog comparator side
   input wire logic below_threshold,
   output logic comparator_en,
   output logic reference_en,
   output logic [2:0] detection_threshold,
   // Responses
   output logic undervoltage_irq,
   output logic undervoltage_reset_req,
   output logic undervoltage_reset_cause
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] ctrl_r, ctrl_nxt, ctrl_wr;
   logic [7:0] lvl_r, lvl_nxt, lvl_wr;
   logic flag_r, flag_nxt;
   logic rst_req_r, rst_req_nxt;
   logic cause_r, cause_nxt;
   logic irq_r, irq_nxt, cmp_r, cmp_nxt, ref_r, ref_nxt;
   logic [2:0] thr_r, thr_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic sel_ctrl, sel_lvl;

   assign sel_ctrl = addr == lvd_pkg::UNDERVOLTAGE_CONTROL_ADDR;
   assign sel_lvl = addr == lvd_pkg::LEVEL_SELECT_ADDR;

   lvd_bitwr #(.MASK(lvd_pkg::CTRL_WRITE_MASK)) u_ctrl_wr (
      .cur(ctrl_r),
      .wdata(wdata),
      .wr_byte(wr_byte && sel_ctrl),
      .wr_bit(wr_bit && sel_ctrl),
      .bit_sel(bit_sel),
      .result(ctrl_wr)
   );

   lvd_bitwr #(.MASK(lvd_pkg::LEVEL_WRITE_MASK)) u_lvl_wr (
      .cur(lvl_r),
      .wdata(wdata),
      .wr_byte(wr_byte && sel_lvl),
      .wr_bit(wr_bit && sel_lvl),
      .bit_sel(bit_sel),
      .result(lvl_wr)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic on, intr_mode;
      on = ctrl_r[lvd_pkg::DETECTOR_ON_BIT];
      intr_mode = !ctrl_r[lvd_pkg::RESPONSE_SELECT_BIT];
      ctrl_nxt = ctrl_wr;
      lvl_nxt = lvl_wr;
      // Ignore a level write beyond the levels this variant offers; keep the old value
      if (lvl_wr[2:0] > 3'(LEVELS - 1)) begin
         lvl_nxt = lvl_r;
      end
      flag_nxt = on && below_threshold;
      irq_nxt = on && intr_mode && flag_r;
      rst_req_nxt = on && !intr_mode && flag_r;
      cause_nxt = cause_r || rst_req_r;
      cmp_nxt = ctrl_nxt[lvd_pkg::DETECTOR_ON_BIT];
      ref_nxt = POC_FITTED ? 1'b1 :
         ctrl_nxt[lvd_pkg::REFERENCE_ENABLE_BIT];
      thr_nxt = lvl_nxt[lvd_pkg::LEVEL_WIDTH-1:0];
      rdata_nxt = 8'h00;
      if (sel_ctrl) begin
         rdata_nxt = (ctrl_r & lvd_pkg::CTRL_WRITE_MASK) |
            {7'h00, flag_r};
      end else if (sel_lvl) begin
         rdata_nxt = lvl_r & lvd_pkg::LEVEL_WRITE_MASK;
      end
      // Non-detector internal reset clears control; detector reset keeps it
      if (internal_reset && !rst_req_r) begin
         ctrl_nxt = lvd_pkg::CTRL_RESET;
         lvl_nxt = lvd_pkg::LEVEL_RESET;
         cmp_nxt = 1'b0;
         ref_nxt = POC_FITTED;
         thr_nxt = 3'h0;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_r <= lvd_pkg::CTRL_RESET;
         lvl_r <= lvd_pkg::LEVEL_RESET;
         flag_r <= 1'b0;
         irq_r <= 1'b0;
         rst_req_r <= 1'b0;
         cause_r <= 1'b0;
         cmp_r <= 1'b0;
         ref_r <= POC_FITTED;
         thr_r <= 3'h0;
         rdata_r <= 8'h00;
      end else begin
         ctrl_r <= ctrl_nxt;
         lvl_r <= lvl_nxt;
         flag_r <= flag_nxt;
         irq_r <= irq_nxt;
         rst_req_r <= rst_req_nxt;
         cause_r <= cause_nxt;
         cmp_r <= cmp_nxt;
         ref_r <= ref_nxt;
         thr_r <= thr_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata = rdata_r;
   assign comparator_en = cmp_r;
   assign reference_en = ref_r;
   assign detection_threshold = thr_r;
   assign undervoltage_irq = irq_r;
   assign undervoltage_reset_req = rst_req_r;
   assign undervoltage_reset_cause = cause_r;
endmodule // lvd_control

//--- sim/lvd_control_chk.sv
module lvd_control_chk (
   // Clock, resets and requests
   input wire logic clk,
   input wire logic reset_n,
   input wire logic internal_reset,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_byte,
   // Observed outputs
   input wire logic [7:0] rdata,
   input wire logic comparator_en,
   input wire logic reference_en,
   input wire logic undervoltage_irq,
   input wire logic undervoltage_reset_req,
   input wire logic undervoltage_reset_cause
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic ctl_wr;
   assign ctl_wr = wr_byte && addr == 16'hFFBE && !internal_reset;
   a_ext_reset_clear: assert property (
      disable iff (1'b0) $rose(reset_n) |->
      rdata == 8'h00 && !comparator_en) else $error("reset values wrong");
   a_on_follows: assert property (
      ctl_wr |=> comparator_en == $past(wdata[7]))
      else $error("comparator enable wrong");
   a_ref_follows: assert property (
      ctl_wr |=> reference_en == $past(wdata[4]))
      else $error("reference enable wrong");
   a_resp_off: assert property (
      !comparator_en && !$past(comparator_en) |->
      !undervoltage_irq && !undervoltage_reset_req)
      else $error("response while off");
   a_unused_zero: assert property (
      $past(addr) == 16'hFFBE |-> (rdata & 8'h6C) == 8'h00)
      else $error("unused bits not zero");
   a_keep_on_own: assert property (
      internal_reset && undervoltage_reset_req && !wr_byte
      |=> $stable(comparator_en)) else $error("control lost");
   a_clear_on_other: assert property (
      internal_reset && !undervoltage_reset_req
      |=> !comparator_en && !reference_en) else $error("control kept");
   a_cause_set: assert property (
      undervoltage_reset_req |=> undervoltage_reset_cause)
      else $error("reset cause not set");
   cover property (undervoltage_irq);
   cover property (internal_reset && undervoltage_reset_req);
   cover property (internal_reset && !undervoltage_reset_req);
endmodule // lvd_control_chk
bind lvd_control lvd_control_chk lvd_control_chk_i (.*);

//--- sim/test_low_voltage_detect_control.sv
module test_low_voltage_detect_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset_n = 0, internal_reset = 0, wr_byte = 0, wr_bit = 0;
   logic below_threshold = 0;
   logic [2:0] bit_sel = 3'h0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00, rdata;
   logic comparator_en, reference_en, undervoltage_irq;
   logic undervoltage_reset_req, undervoltage_reset_cause;
   logic [2:0] detection_threshold;
   int failures = 0, check_count = 0, cycles = 0;
   // Scaled-down stand-in for the software settle waits
   localparam int SETTLE_CYCLES = 20;
   lvd_control lvd_control_i (.*);
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         failures++;
         finish_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b,
                     input logic [2:0] s);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_byte <= b;
      wr_bit <= !b;
      bit_sel <= s;
      @(posedge clk);
      wr_byte <= 1'b0;
      wr_bit <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge clk);
      addr <= a;
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic pulse_reset();
      @(posedge clk);
      internal_reset <= 1'b1;
      @(posedge clk);
      internal_reset <= 1'b0;
   endtask
   task automatic t_reset();
      rd(16'hFFBE);
      chk(rdata, 8'h00);
      rd(16'hFFBF);
      chk(rdata, 8'h00);
   endtask
   task automatic t_write_mask();
      wr(16'hFFBE, 8'hFF, 1'b1, 3'h0);
      rd(16'hFFBE);
      chk(rdata, 8'h92);
      wr(16'hFFBE, 8'h00, 1'b0, 3'h7);
      rd(16'hFFBE);
      chk(rdata, 8'h12);
      chk(8'(reference_en), 8'h01);
      wr(16'hFFBF, 8'hFD, 1'b1, 3'h0);
      @(negedge clk);
      chk(8'(detection_threshold), 8'h05);
   endtask
   task automatic t_interrupt();
      wr(16'hFFBE, 8'h10, 1'b1, 3'h0);
      repeat (SETTLE_CYCLES) @(posedge clk);
      wr(16'hFFBE, 8'h91, 1'b1, 3'h0);
      below_threshold <= 1'b1;
      repeat (SETTLE_CYCLES) @(posedge clk);
      rd(16'hFFBE);
      chk(rdata, 8'h91);
      repeat (2) @(negedge clk);
      chk(8'(undervoltage_irq), 8'h01);
      chk(8'(undervoltage_reset_req), 8'h00);
   endtask
   task automatic t_detector_reset();
      wr(16'hFFBE, 8'h02, 1'b0, 3'h1);
      repeat (3) @(negedge clk);
      chk(8'(undervoltage_reset_req), 8'h01);
      chk(8'(undervoltage_irq), 8'h00);
      pulse_reset();
      rd(16'hFFBE);
      chk(rdata, 8'h93);
      chk(8'(undervoltage_reset_cause), 8'h01);
   endtask
   task automatic t_other_reset();
      below_threshold <= 1'b0;
      repeat (4) @(posedge clk);
      pulse_reset();
      rd(16'hFFBE);
      chk(rdata, 8'h00);
      chk(8'(comparator_en), 8'h00);
   endtask
   task automatic t_stop();
      wr(16'hFFBE, 8'h10, 1'b1, 3'h0);
      repeat (SETTLE_CYCLES) @(posedge clk);
      wr(16'hFFBE, 8'h80, 1'b0, 3'h7);
      @(negedge clk);
      chk(8'(comparator_en), 8'h01);
      wr(16'hFFBE, 8'h00, 1'b0, 3'h7);
      wr(16'hFFBE, 8'h00, 1'b0, 3'h4);
      @(negedge clk);
      chk(8'(comparator_en), 8'h00);
      chk(8'(reference_en), 8'h00);
      rd(16'hFFBE);
      chk(rdata, 8'h00);
   endtask
   task automatic finish_test();
      if (failures == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_write_mask();
      t_interrupt();
      t_detector_reset();
      t_other_reset();
      t_stop();
      finish_test();
   end
endmodule // test_low_voltage_detect_control
